// ---- logic/bprb_regs.svh ----
// register offsets, field positions and reset values of the protection register bank
`ifndef BPRB_REGS_SVH
`define BPRB_REGS_SVH
// ===========================================
// register offsets
`define BPRB_CASCADE_POSITION_STATUS 8'h00
`define BPRB_FAULT_STATUS 8'h01
`define BPRB_BALANCE_SWITCH_CONTROL 8'h02
`define BPRB_MONITOR_OUTPUT_SELECT 8'h03
`define BPRB_SWITCH_DRIVE_CONTROL 8'h04
`define BPRB_DISCHARGE_PROTECT_CONFIG 8'h05
`define BPRB_CHARGE_PROTECT_CONFIG 8'h06
`define BPRB_FEATURE_CONFIG 8'h07
`define BPRB_CONFIG_WRITE_UNLOCK 8'h08
`define BPRB_LAST_ADDR 8'h08
// ===========================================
// field positions
`define BPRB_UPPER_CASCADE_BIT 7
`define BPRB_LOWER_CASCADE_BIT 6
`define BPRB_WAKE_PIN_BIT 4
`define BPRB_EXT_OT_BIT 5
`define BPRB_INT_OT_BIT 4
`define BPRB_LOAD_FAIL_BIT 3
`define BPRB_DSC_BIT 2
`define BPRB_DOC_BIT 1
`define BPRB_COC_BIT 0
`define BPRB_SLEEP_BIT 7
`define BPRB_LOAD_MON_BIT 6
`define BPRB_CHG_SW_BIT 1
`define BPRB_DIS_SW_BIT 0
`define BPRB_DOC_AUTO_OFF_BIT 7
`define BPRB_SC_AUTO_OFF_BIT 4
`define BPRB_COC_AUTO_OFF_BIT 7
`define BPRB_CHARGE_TIME_DIVIDER_BIT 3
`define BPRB_DISCHARGE_TIME_DIVIDER_BIT 2
`define BPRB_TEMP_SCAN_OFF_BIT 7
`define BPRB_REG_DISABLE_BIT 6
`define BPRB_TEMP_KEEP_BIT 5
`define BPRB_EXT_TSD_OFF_BIT 4
`define BPRB_INT_TSD_OFF_BIT 3
`define BPRB_FORCE_POR_BIT 2
`define BPRB_WAKE_DIS_BIT 1
`define BPRB_WAKE_POL_BIT 0
`define BPRB_FEAT_UNLOCK_BIT 7
`define BPRB_CHG_UNLOCK_BIT 6
`define BPRB_DIS_UNLOCK_BIT 5
// ===========================================
// writable masks (reserved bits kept at zero)
`define BPRB_BALANCE_MASK 8'hfe
`define BPRB_MONITOR_MASK 8'hcf
`define BPRB_DRIVE_MASK 8'hc3
`define BPRB_UNLOCK_MASK 8'hf8
`define BPRB_RESET_VALUE 8'h00
// ===========================================
// timing counts
`define BPRB_CHG_DIV 32
`define BPRB_DIS_DIV 64
`endif

// ---- logic/bprb_pkg.sv ----
// types shared by both ends of the protection register bank
package bprb_pkg;
    typedef logic [7:0] bprb_byte_t; // one register byte
    typedef enum logic [1:0] {
        BPRB_IDLE = 2'b00,
        BPRB_WRITE = 2'b01,
        BPRB_READ = 2'b10,
        BPRB_WAIT = 2'b11
    } bprb_state_e;
endpackage

// ---- logic/bprb_link_if.sv ----
// link between the host controller and the protection register bank
`timescale 1ns/100ps
interface bprb_link_if;
    logic link_clk; // link clock driven by the host
    logic req; // toggle: new request
    logic wr; // request is a write
    logic [7:0] addr; // register address
    logic [7:0] wdata; // write data
    logic ack; // toggle: request done
    logic [7:0] rdata; // read data, valid with ack
    modport host (output link_clk, output req, output wr, output addr, output wdata,
                  input ack, input rdata);
    modport dev (input link_clk, input req, input wr, input addr, input wdata,
                 output ack, output rdata);
endinterface

// ---- logic/bprb_device.sv ----
// protection register bank, device end, clocked by the link clock
// Function
// (RQ1) writing one performs action, reading one means present
// (RQ2) host writes reserved bits as zero
// (RQ3) host never writes addresses 09H to FFH
// (RQ4) host ignores reserved bits read back
// (RQ5) fault flags clear on status read
// (RQ6) cascade status bits follow live condition
// (RQ7) sleep clears: power-up, zero write, wake edge
// (RQ8) auto protection clears FET bits on trip
// (RQ9) host write drives FETs; read shows drive
// (RQ10) config writes need matching unlock bit
// (RQ11) charge set bits divide time-outs 32, 64
// (RQ12) top feature bit stops temperature scan
// (RQ13) feature bit disables internal 3.3V regulator
// (RQ14) feature bits disable external, internal thermal shutdown
// (RQ15) Switch_drive_control bit enables load monitor
// (RQ16) FET bits one, zero drive charge, discharge
// (RQ17) upper device unused status reads zero
// (RQ18) upper device unused registers accept, do nothing
// (RQ19) fault flags set on condition, hold while present
// (RQ20) balance bits drive cell switches, bit six wakes
// (RQ21) analog select low nibble, top bits user flags
`timescale 1ns/100ps
`include "bprb_regs.svh"
module bprb_device #(
    parameter bit UPPER_DEVICE = 1'b0 // one in the upper cascade device
) (
    input wire logic nrst_in, // asynchronous, active low
    bprb_link_if.dev link, // host link, clocks this end
    input wire logic wake_pin_in, // raw wake pin
    input wire logic ext_ot_in, // external over-temperature condition
    input wire logic int_ot_in, // internal over-temperature condition
    input wire logic load_heavy_in, // load still heavy after trip
    input wire logic short_in, // discharge short condition
    input wire logic dis_oc_in, // discharge overcurrent condition
    input wire logic chg_oc_in, // charge overcurrent condition
    output logic [7:1] balance_cell_out, // cell balance switches 7..1
    output logic remote_wake_request_out, // wake forwarded upward
    output logic [3:0] monitor_select_out, // analog output select
    output logic charge_switch_on_out, // charge FET drive
    output logic discharge_switch_on_out, // discharge FET drive
    output logic load_monitor_enable_out, // load voltage monitor connect
    output logic sleep_out, // force sleep
    output logic [7:0] discharge_cfg_out, // discharge thresholds and delays
    output logic [2:0] charge_cfg_out, // charge threshold and delay code
    output logic long_short_delay_out, // long short-circuit delay
    output logic charge_time_divider_out, // charge time-out / 32
    output logic discharge_time_divider_out, // discharge time-out / 64
    output logic temp_scan_off_out, // stop periodic temp scan
    output logic regulator_disable_out, // internal regulator off
    output logic temp_supply_keep_on_out, // temp supply kept on
    output logic ext_thermal_shutdown_off_out, // no thermistor shutdown
    output logic int_thermal_shutdown_off_out, // no die-temp shutdown
    output logic force_por_out // force power-on reset request
);
    import bprb_pkg::*;
    // ===========================================
    // synchronisers: pin inputs pass two flops
    logic [6:0] sync1_r; // first stage, read only by second stage
    logic [6:0] sync2_r; // second stage, safe to use
    logic [6:0] sync2_nxt;
    logic [2:0] req_sync_r; // request toggle: two stages plus edge copy
    logic [2:0] req_sync_nxt;
    always_comb begin
        sync2_nxt = sync1_r;
        req_sync_nxt = {req_sync_r[1:0], link.req};
    end
    always_ff @(posedge link.link_clk or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
            req_sync_r <= 3'h0;
        end else begin
            sync1_r <= {wake_pin_in, ext_ot_in, int_ot_in, load_heavy_in,
                        short_in, dis_oc_in, chg_oc_in};
            sync2_r <= sync2_nxt;
            req_sync_r <= req_sync_nxt;
        end
    end
    logic wake_pin; // synced wake pin
    logic [5:0] cond; // synced fault conditions, status bit order
    logic req_edge; // new request seen
    assign wake_pin = sync2_r[6];
    assign cond = sync2_r[5:0];
    assign req_edge = req_sync_r[2] ^ req_sync_r[1];
    // ===========================================
    // register bank state
    bprb_byte_t fault_r, fault_nxt; // sticky fault flags
    bprb_byte_t bal_r, bal_nxt; // balance control
    bprb_byte_t mon_r, mon_nxt; // monitor select and user flags
    bprb_byte_t drv_r, drv_nxt; // switch drive control
    bprb_byte_t dcfg_r, dcfg_nxt; // discharge config
    bprb_byte_t ccfg_r, ccfg_nxt; // charge config
    bprb_byte_t feat_r, feat_nxt; // feature config
    bprb_byte_t unl_r, unl_nxt; // write unlock and user flags
    logic wake_prev_r, wake_prev_nxt; // wake pin last cycle
    logic ack_r, ack_nxt; // ack toggle
    bprb_byte_t rdata_r, rdata_nxt; // read data
    logic wr_hit, rd_hit; // decoded access strobes
    bprb_byte_t cfg_status; // cascade/wake status view
    logic auto_trip; // automatic FET turn-off event
    logic wake_event; // wake edge of selected polarity
    assign wr_hit = req_edge && link.wr;
    assign rd_hit = req_edge && !link.wr;
    // ===========================================
    // next-state logic
    always_comb begin
        fault_nxt = fault_r;
        bal_nxt = bal_r;
        mon_nxt = mon_r;
        drv_nxt = drv_r;
        dcfg_nxt = dcfg_r;
        ccfg_nxt = ccfg_r;
        feat_nxt = feat_r;
        unl_nxt = unl_r;
        ack_nxt = ack_r;
        rdata_nxt = rdata_r;
        wake_prev_nxt = wake_pin;
        // live status: polarity-corrected wake pin, cascade position
        cfg_status = 8'h00; // RQ6
        cfg_status[`BPRB_UPPER_CASCADE_BIT] = UPPER_DEVICE;
        cfg_status[`BPRB_LOWER_CASCADE_BIT] = !UPPER_DEVICE;
        cfg_status[`BPRB_WAKE_PIN_BIT] = wake_pin ~^ feat_r[`BPRB_WAKE_POL_BIT]; // RQ6
        wake_event = !feat_r[`BPRB_WAKE_DIS_BIT] && (wake_pin != wake_prev_r) &&
                     (wake_pin == feat_r[`BPRB_WAKE_POL_BIT]); // RQ7
        auto_trip = (cond[`BPRB_DSC_BIT] && !dcfg_r[`BPRB_SC_AUTO_OFF_BIT]) ||
                    (cond[`BPRB_DOC_BIT] && !dcfg_r[`BPRB_DOC_AUTO_OFF_BIT]) ||
                    (cond[`BPRB_COC_BIT] && !ccfg_r[`BPRB_COC_AUTO_OFF_BIT]);
        // read answers; a status read clears flags whose cause is gone
        if (rd_hit) begin
            ack_nxt = !ack_r;
            unique case (link.addr)
                `BPRB_CASCADE_POSITION_STATUS: rdata_nxt = cfg_status;
                `BPRB_FAULT_STATUS: begin
                    rdata_nxt = UPPER_DEVICE ? 8'h00 : fault_r; // RQ17
                    fault_nxt = fault_r & {2'b00, cond}; // RQ5 RQ19
                end
                `BPRB_BALANCE_SWITCH_CONTROL: rdata_nxt = bal_r;
                `BPRB_MONITOR_OUTPUT_SELECT: rdata_nxt = mon_r;
                `BPRB_SWITCH_DRIVE_CONTROL: rdata_nxt = drv_r; // RQ9
                `BPRB_DISCHARGE_PROTECT_CONFIG: rdata_nxt = dcfg_r;
                `BPRB_CHARGE_PROTECT_CONFIG: rdata_nxt = ccfg_r;
                `BPRB_FEATURE_CONFIG: rdata_nxt = feat_r;
                `BPRB_CONFIG_WRITE_UNLOCK: rdata_nxt = unl_r;
                default: rdata_nxt = 8'h00; // reserved space reads zero
            endcase
        end
        // writes; reserved registers ignored, locked configs ignored
        if (wr_hit) begin
            ack_nxt = !ack_r;
            unique case (link.addr)
                `BPRB_BALANCE_SWITCH_CONTROL: bal_nxt = link.wdata & `BPRB_BALANCE_MASK; // RQ20
                `BPRB_MONITOR_OUTPUT_SELECT: mon_nxt = link.wdata & `BPRB_MONITOR_MASK; // RQ21
                `BPRB_SWITCH_DRIVE_CONTROL: drv_nxt = link.wdata & `BPRB_DRIVE_MASK; // RQ1 RQ9
                `BPRB_DISCHARGE_PROTECT_CONFIG: begin
                    if (unl_r[`BPRB_DIS_UNLOCK_BIT]) dcfg_nxt = link.wdata; // RQ10
                end
                `BPRB_CHARGE_PROTECT_CONFIG: begin
                    if (unl_r[`BPRB_CHG_UNLOCK_BIT]) ccfg_nxt = link.wdata; // RQ10
                end
                `BPRB_FEATURE_CONFIG: begin
                    if (unl_r[`BPRB_FEAT_UNLOCK_BIT]) feat_nxt = link.wdata; // RQ10
                end
                `BPRB_CONFIG_WRITE_UNLOCK: unl_nxt = link.wdata & `BPRB_UNLOCK_MASK;
                // status, reserved and unused upper registers: no effect
                default: ; // RQ18
            endcase
        end
        // hardware set wins over read clear
        if (!UPPER_DEVICE) begin
            fault_nxt = fault_nxt | {2'b00, cond}; // RQ19
        end else begin
            fault_nxt = 8'h00; // RQ17
        end
        if (wake_event) begin
            drv_nxt[`BPRB_SLEEP_BIT] = 1'b0; // RQ7
        end
        if (auto_trip && !UPPER_DEVICE) begin
            drv_nxt[`BPRB_CHG_SW_BIT] = 1'b0; // RQ8
            drv_nxt[`BPRB_DIS_SW_BIT] = 1'b0; // RQ8
        end
    end
    // ===========================================
    // registers; reset stands in for power-up (sleep clear)
    always_ff @(posedge link.link_clk or negedge nrst_in) begin
        if (!nrst_in) begin
            fault_r <= `BPRB_RESET_VALUE;
            bal_r <= `BPRB_RESET_VALUE;
            mon_r <= `BPRB_RESET_VALUE;
            drv_r <= `BPRB_RESET_VALUE; // RQ7
            dcfg_r <= `BPRB_RESET_VALUE;
            ccfg_r <= `BPRB_RESET_VALUE;
            feat_r <= `BPRB_RESET_VALUE;
            unl_r <= `BPRB_RESET_VALUE;
            wake_prev_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            fault_r <= fault_nxt;
            bal_r <= bal_nxt;
            mon_r <= mon_nxt;
            drv_r <= drv_nxt;
            dcfg_r <= dcfg_nxt;
            ccfg_r <= ccfg_nxt;
            feat_r <= feat_nxt;
            unl_r <= unl_nxt;
            wake_prev_r <= wake_prev_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    // ===========================================
    // outputs straight from flops
    assign link.ack = ack_r;
    assign link.rdata = rdata_r;
    assign balance_cell_out = bal_r[7:1]; // RQ20
    assign remote_wake_request_out = bal_r[6]; // RQ20
    assign monitor_select_out = mon_r[3:0]; // RQ21
    assign charge_switch_on_out = drv_r[`BPRB_CHG_SW_BIT]; // RQ16
    assign discharge_switch_on_out = drv_r[`BPRB_DIS_SW_BIT]; // RQ16
    assign load_monitor_enable_out = drv_r[`BPRB_LOAD_MON_BIT]; // RQ15
    assign sleep_out = drv_r[`BPRB_SLEEP_BIT];
    assign discharge_cfg_out = dcfg_r;
    assign charge_cfg_out = {ccfg_r[6:5], ccfg_r[0]};
    assign long_short_delay_out = ccfg_r[4];
    assign charge_time_divider_out = ccfg_r[`BPRB_CHARGE_TIME_DIVIDER_BIT]; // RQ11
    assign discharge_time_divider_out = ccfg_r[`BPRB_DISCHARGE_TIME_DIVIDER_BIT]; // RQ11
    assign temp_scan_off_out = feat_r[`BPRB_TEMP_SCAN_OFF_BIT]; // RQ12
    assign regulator_disable_out = feat_r[`BPRB_REG_DISABLE_BIT]; // RQ13
    assign temp_supply_keep_on_out = feat_r[`BPRB_TEMP_KEEP_BIT];
    assign ext_thermal_shutdown_off_out = feat_r[`BPRB_EXT_TSD_OFF_BIT]; // RQ14
    assign int_thermal_shutdown_off_out = feat_r[`BPRB_INT_TSD_OFF_BIT]; // RQ14
    assign force_por_out = feat_r[`BPRB_FORCE_POR_BIT];
endmodule

// ---- logic/bprb_host.sv ----
// host end: takes user requests, divides its clock into the link clock
`timescale 1ns/100ps
`include "bprb_regs.svh"
module bprb_host #(
    parameter int CLK_DIV = 3 // half-period of link clock in clk_in cycles
) (
    input wire logic clk_in, // 125 MHz system clock
    input wire logic nrst_in, // asynchronous, active low
    bprb_link_if.host link, // link to the device
    input wire logic cmd_valid_in, // request pulse
    input wire logic cmd_write_in, // request is a write
    input wire logic [7:0] cmd_addr_in, // register address
    input wire logic [7:0] cmd_wdata_in, // write data
    output logic cmd_ready_out, // idle, may take a request
    output logic done_out, // one-cycle completion pulse
    output logic [7:0] rdata_out // read data, valid with done
);
    import bprb_pkg::*;
    // ===========================================
    // state
    bprb_state_e state_r, state_nxt; // request sequencer
    logic [7:0] div_r, div_nxt; // link clock divider
    logic lclk_r, lclk_nxt; // link clock
    logic req_r, req_nxt; // request toggle
    logic wr_r, wr_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [1:0] ack_sync_r; // ack toggle synchroniser
    logic ack_seen_r, ack_seen_nxt; // last acknowledged toggle
    logic [7:0] rd_sync1_r, rd_sync2_r; // read data synchroniser, same two-stage depth as ack; the device updates it on the edge that toggles ack
    logic ready_r, ready_nxt;
    logic done_r, done_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    // ===========================================
    // next values
    always_comb begin
        state_nxt = state_r;
        div_nxt = div_r + 8'h01;
        lclk_nxt = lclk_r;
        req_nxt = req_r;
        wr_nxt = wr_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        ack_seen_nxt = ack_seen_r;
        ready_nxt = ready_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        // free-running divider; the device relies on a steady clock
        if (div_r == 8'(CLK_DIV - 1)) begin
            div_nxt = 8'h00;
            lclk_nxt = !lclk_r;
        end
        unique case (state_r)
            BPRB_IDLE: begin
                if (cmd_valid_in) begin
                    // never writes reserved space (RQ3); bits masked by caller
                    if (cmd_write_in && cmd_addr_in > `BPRB_LAST_ADDR) begin
                        done_nxt = 1'b1; // RQ3
                    end else begin
                        wr_nxt = cmd_write_in;
                        addr_nxt = cmd_addr_in;
                        wdata_nxt = cmd_wdata_in;
                        state_nxt = BPRB_WAIT;
                        ready_nxt = 1'b0;
                    end
                end
            end
            BPRB_WAIT: begin
                // data held steady one clock before toggling request
                req_nxt = !req_r;
                state_nxt = wr_r ? BPRB_WRITE : BPRB_READ;
            end
            BPRB_WRITE, BPRB_READ: begin
                if (ack_sync_r[1] != ack_seen_r) begin
                    ack_seen_nxt = ack_sync_r[1];
                    done_nxt = 1'b1;
                    rdata_nxt = wr_r ? 8'h00 : rd_sync2_r;
                    ready_nxt = 1'b1;
                    state_nxt = BPRB_IDLE;
                end
            end
        endcase
    end
    // ===========================================
    // registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= BPRB_IDLE;
            div_r <= 8'h00;
            lclk_r <= 1'b0;
            req_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            ack_sync_r <= 2'h0;
            ack_seen_r <= 1'b0;
            rd_sync1_r <= 8'h00;
            rd_sync2_r <= 8'h00;
            ready_r <= 1'b1;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            lclk_r <= lclk_nxt;
            req_r <= req_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            ack_sync_r <= {ack_sync_r[0], link.ack};
            ack_seen_r <= ack_seen_nxt;
            rd_sync1_r <= link.rdata;
            rd_sync2_r <= rd_sync1_r;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign link.link_clk = lclk_r;
    assign link.req = req_r;
    assign link.wr = wr_r;
    assign link.addr = addr_r;
    assign link.wdata = wdata_r;
    assign cmd_ready_out = ready_r;
    assign done_out = done_r;
    assign rdata_out = rdata_r;
endmodule

// ---- testbench/bprb_assertions.sv ----
// link checker for the protection register bank, host end to device end
`timescale 1ns/100ps
module bprb_assertions (
    input wire logic nrst_in, // reset, active low
    input wire logic link_clk, // host-made link clock
    input wire logic req, // request toggle
    input wire logic wr, // write flag
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic ack, // answer toggle
    input wire logic [7:0] rdata // read data
);
    // ==========
    // handshake: one request in flight, answered in bounded time
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!nrst_in);
    // the host may toggle the next request before the following link edge
    ack_match_a: assert property ($changed(ack) |-> ack == $past(req))
        else $error("answer toggled with no request pending");
    ack_bound_a: assert property ($changed(req) |-> ##[1:8] $changed(ack))
        else $error("request not answered in time");
    req_hold_a: assert property ((req != ack) |=> $stable(req) || $changed(ack))
        else $error("request toggled while pending");
    addr_hold_a: assert property ((req != ack) |=> $stable(addr) || $changed(ack))
        else $error("address moved while pending");
    data_hold_a: assert property ((req != ack) |=> $stable({wr, wdata}) || $changed(ack))
        else $error("write data moved while pending");
    // ==========
    // reserved places never written, read as zero
    far_write_a: assert property ($changed(req) |-> !(wr && addr > 8'h08))
        else $error("write sent to a reserved address");
    // request fields taken one edge back: the next request may already be latched
    far_read_a: assert property ($changed(ack) && !$past(wr) && $past(addr) > 8'h08 |->
        rdata == 8'h00)
        else $error("reserved address read nonzero");
    unlock_res_a: assert property ($changed(ack) && !$past(wr) && $past(addr) == 8'h08 |->
        rdata[2:0] == 3'h0)
        else $error("unlock reserved bits nonzero");
    status_res_a: assert property ($changed(ack) && !$past(wr) && $past(addr) == 8'h01 |->
        rdata[7:6] == 2'h0)
        else $error("fault status reserved bits nonzero");
endmodule

// ---- testbench/battery_protect_register_bank_test.sv ----
// self-checking bench: host end and device end joined by the link
`timescale 1ns/100ps
module battery_protect_register_bank_test;
    logic clk = 0; // 125 MHz system clock
    logic nrst = 1; // reset, active low; lowered at 1 ns so the async reset sees an edge
    logic cv = 0; // request valid
    logic cw = 0; // request is a write
    logic [7:0] ca = 0; // request address
    logic [7:0] cd = 0; // request write data
    logic [5:0] cond = 0; // ext ot, int ot, load, short, dis oc, chg oc
    logic wake = 0; // wake pin level
    logic ready, done, rwk, csw, dsw, lmon, slp, lsd, ctd, dtd;
    logic tso, rdis, tko, xtso, itso, fpor;
    logic [7:0] rd, dcfg, q, ra, rw;
    logic [7:1] bal;
    logic [3:0] msel;
    logic [2:0] ccfg;
    logic [7:0] mdl [0:8]; // model of the register bytes
    int failures = 0;
    int n_tests = 0;
    // ==========
    // clock, link and the two ends
    always #4 clk = ~clk;
    bprb_link_if lk();
    bprb_host #(.CLK_DIV(3)) i_bprb_host (.clk_in(clk), .nrst_in(nrst), .link(lk),
        .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_addr_in(ca), .cmd_wdata_in(cd),
        .cmd_ready_out(ready), .done_out(done), .rdata_out(rd));
    bprb_device i_bprb_device (.nrst_in(nrst), .link(lk), .wake_pin_in(wake),
        .ext_ot_in(cond[5]), .int_ot_in(cond[4]), .load_heavy_in(cond[3]),
        .short_in(cond[2]), .dis_oc_in(cond[1]), .chg_oc_in(cond[0]),
        .balance_cell_out(bal), .remote_wake_request_out(rwk), .monitor_select_out(msel),
        .charge_switch_on_out(csw), .discharge_switch_on_out(dsw),
        .load_monitor_enable_out(lmon), .sleep_out(slp), .discharge_cfg_out(dcfg),
        .charge_cfg_out(ccfg), .long_short_delay_out(lsd), .charge_time_divider_out(ctd),
        .discharge_time_divider_out(dtd), .temp_scan_off_out(tso),
        .regulator_disable_out(rdis), .temp_supply_keep_on_out(tko),
        .ext_thermal_shutdown_off_out(xtso), .int_thermal_shutdown_off_out(itso),
        .force_por_out(fpor));
    bprb_assertions i_bprb_assertions (.nrst_in(nrst), .link_clk(lk.link_clk),
        .req(lk.req), .wr(lk.wr), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack),
        .rdata(lk.rdata));
    // ==========
    // compare, transfer and model update
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one request; model follows unlock gating, refused addresses leave it alone
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cw = w;
        ca = a;
        cd = d;
        cv = 1;
        @(posedge clk);
        #1 cv = 0;
        chk(ready, w && a > 8'h08);
        while (done !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        if (done !== 1'b1) failures++;
        chk(ready, 1'b1);
        q = rd;
        if (w && a >= 2 && a <= 8 && (a < 5 || a == 8 || mdl[8][a[2:0]])) mdl[a] = d;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(q & m, e);
    endtask
    // writable bits; stimulus keeps reserved, reset and wake bits clear
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h02: msk = 8'hfe;
            8'h03: msk = 8'hcf;
            8'h04: msk = 8'hc3;
            8'h07: msk = 8'hf8;
            8'h08: msk = 8'hf8;
            default: msk = 8'hff;
        endcase
    endfunction
    task automatic outs;
        chk({bal, 1'b0}, mdl[2] & 8'hfe);
        chk(rwk, mdl[2][6]);
        chk(msel, mdl[3][3:0]);
        chk({slp, lmon, csw, dsw}, {mdl[4][7:6], mdl[4][1:0]});
        chk(dcfg, mdl[5]);
        chk({ccfg, lsd, ctd, dtd}, {mdl[6][6:5], mdl[6][0], mdl[6][4:2]});
        chk({tso, rdis, tko, xtso, itso, fpor}, mdl[7][7:2]);
    endtask
    task automatic settle;
        repeat (60) @(posedge clk);
        #1;
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========
    // watchdog, well beyond the expected run
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        stop_test;
    end
    // ==========
    // main sequence
    initial begin
        mdl = '{default: 8'h00};
        void'($urandom(32'hfde60eb8));
        #1 nrst = 0;
        repeat (4) @(posedge clk);
        #1 nrst = 1;
        @(posedge clk);
        #1 rd_chk(8'h00, 8'hd0, 8'h50);
        for (int a = 1; a < 9; a++) rd_chk(8'(a), 8'hff, 8'h00);
        outs;
        $display("test reset done");
        // random traffic, locked and reserved addresses included
        for (int i = 0; i < 40; i++) begin
            ra = 8'(2 + $urandom % 14);
            rw = 8'($urandom) & msk(ra);
            xfer(1'b1, ra, rw);
            outs;
            rd_chk(ra, msk(ra), ra > 8 ? 8'h00 : mdl[ra]);
        end
        for (int u = 0; u < 2; u++) begin
            xfer(1'b1, 8'h08, u ? 8'he0 : 8'h00);
            for (int a = 5; a < 8; a++) begin
                xfer(1'b1, 8'(a), 8'h58 ^ mdl[a]);
                rd_chk(8'(a), 8'hff, mdl[a]);
            end
            outs;
        end
        $display("test registers done");
        // each fault condition: trip, hold, clear on read
        xfer(1'b1, 8'h05, 8'h00);
        xfer(1'b1, 8'h06, 8'h00);
        for (int k = 0; k < 6; k++) begin
            xfer(1'b1, 8'h04, 8'h03);
            cond = 6'h01 << k;
            settle;
            if (k < 3) mdl[4][1:0] = 2'b00;
            rd_chk(8'h04, 8'hff, mdl[4]);
            outs;
            rd_chk(8'h01, 8'h3f, 8'h01 << k);
            rd_chk(8'h01, 8'h3f, 8'h01 << k);
            cond = 0;
            settle;
            rd_chk(8'h01, 8'h3f, 8'h01 << k);
            rd_chk(8'h01, 8'h3f, 8'h00);
        end
        $display("test faults done");
        // sleep cleared by the wake edge of either polarity, then by a zero write
        for (int p = 0; p < 2; p++) begin
            wake = !p;
            settle;
            xfer(1'b1, 8'h07, 8'(p));
            xfer(1'b1, 8'h04, 8'h80);
            chk(slp, 1'b1);
            wake = p;
            settle;
            mdl[4][7] = 1'b0;
            outs;
            rd_chk(8'h00, 8'h10, 8'h10);
        end
        xfer(1'b1, 8'h04, 8'h80);
        xfer(1'b1, 8'h04, 8'h00);
        chk(slp, 1'b0);
        // wake pin disabled: a matching edge must leave sleep set
        xfer(1'b1, 8'h07, 8'h02);
        xfer(1'b1, 8'h04, 8'h80);
        wake = 0;
        settle;
        chk(slp, 1'b1);
        $display("test sleep done");
        stop_test;
    end
endmodule
